// ---- common/quad_pot_pkg.sv ----
// package: command codes, field positions and timing constants for the quad pot link
package quad_pot_pkg;
  // device type nibble; value arbitrary, not tied to any real part
  localparam logic [3:0] DEV_TYPE        = 4'ha;
  // instruction opcodes (upper nibble of instruction byte)
  localparam logic [3:0] OP_RD_WIPER     = 4'h9;
  localparam logic [3:0] OP_WR_WIPER     = 4'ha;
  localparam logic [3:0] OP_RD_SAVED     = 4'hb;
  localparam logic [3:0] OP_WR_SAVED     = 4'hc;
  localparam logic [3:0] OP_SAVED_TO_WIP = 4'hd;
  localparam logic [3:0] OP_WIP_TO_SAVED = 4'he;
  localparam logic [3:0] OP_G_SAVED_WIP  = 4'h1;
  localparam logic [3:0] OP_G_WIP_SAVED  = 4'h8;
  localparam logic [3:0] OP_STEP         = 4'h2;
  // field positions
  localparam int OPC_LSB  = 4;
  localparam int SLOT_LSB = 2;
  localparam int POT_LSB  = 0;
  localparam int WIPER_W  = 6;
  localparam logic [5:0] WIPER_MAX = 6'h3f;
  localparam logic [5:0] WIPER_MIN = 6'h00;
  localparam logic [5:0] WIPER_RST = 6'h20;
  // non-volatile programming time
  localparam int NV_WRITE_MS  = 5;
  localparam int CLK_MHZ      = 125;
  localparam int NV_WRITE_CYC = NV_WRITE_MS * 1000 * CLK_MHZ;
  // host-side link clock divider: quarter period (one sequencer tick) in reference cycles
  localparam int SCL_HALF_CYC = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
endpackage

// ---- common/quad_pot_if.sv ----
// interface: two-wire link between the bus master and the quad pot device
`timescale 1ns/1ps
interface quad_pot_if;
  logic scl_o;     // master clock drive level
  logic scl_oe_n;  // master clock enable, low drives
  logic m_sda_o;
  logic m_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  wire  scl;
  wire  sda;
  // open-drain resolution, pull-up when released
  assign scl = (!scl_oe_n && !scl_o) ? 1'b0 : 1'b1;
  assign sda = ((!m_sda_oe_n && !m_sda_o) || (!d_sda_oe_n && !d_sda_o)) ? 1'b0 : 1'b1;
  modport master (output scl_o, scl_oe_n, m_sda_o, m_sda_oe_n, input scl, sda);
  modport device (output d_sda_o, d_sda_oe_n, input scl, sda);
endinterface

// ---- hdl/quad_pot_device.sv ----
// quad pot device end: two-wire command decoder, wiper and saved-setting registers
// Functional notes
// [R1] global saved-to-wiper copies slot for all pots
// [R2] global wiper-to-saved stores all wipers into slot
// [R3] after step ack, each pulse moves one tap
// [R4] pulse with data high steps toward high terminal
// [R5] pulse with data low steps toward low terminal
// [R6] wiper read: addr, instr, device data, ack, stop
// [R7] wiper write: addr, instr, data loads wiper
// [R8] saved write: slot bits 3:2, pot 1:0
// [R9] global saved-to-wiper is two bytes only
// [R10] global wiper-to-saved is two bytes only
// [R11] single wiper-to-saved copies after stop
// [R12] single saved-to-wiper loads wiper register
// [R13] step frame: direction bits, no acks, stop
// [R14] non-volatile programming starts only after stop
// [R15] address pins must match or stay idle
// [R16] saved register change takes up to 5 ms
// [R17] wipers are 6-bit, selecting 64 taps
// [R18] saved read returns slot and pot addressed
// [R19] stepping saturates at end taps
// [R20] top two data bits ignored, read zero
`timescale 1ns/1ps
module quad_pot_device #(
  parameter int NV_CYC = quad_pot_pkg::NV_WRITE_CYC
) (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // strap pins
  input  wire logic [3:0]  i_board_address_pins,
  // link
  quad_pot_if.device       link,
  // user side
  output logic [23:0]      o_wiper_taps,
  output logic             o_nv_busy
);
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_ADDR  = 7'b0000010,
    ST_INSTR = 7'b0000100,
    ST_DATA  = 7'b0001000,
    ST_TXD   = 7'b0010000,
    ST_STEP  = 7'b0100000,
    ST_WAIT  = 7'b1000000
  } dev_state_t;

  dev_state_t  state_q;
  logic [5:0]  wiper_position_register [4];
  logic [5:0]  saved_setting_register [4][4];
  logic [1:0]  scl_s_q, sda_s_q;
  logic [3:0]  pin_s1_q, pin_s2_q;
  logic        scl_q, sda_q;
  logic [2:0]  bit_q;
  logic        ack_ph_q, skip_q;
  logic [7:0]  sh_q;
  logic [7:0]  instr_q;
  logic [7:0]  tx_q;
  logic        pend_q;
  logic [1:0]  pend_slot_q, pend_pot_q;
  logic [5:0]  pend_val_q;
  logic        pend_all_q;
  logic [31:0] nv_cnt_q;
  logic        sda_drv_q;

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s_q[1] && !scl_q;
  assign scl_fall = !scl_s_q[1] && scl_q;
  assign start_c  = scl_s_q[1] && scl_q && sda_q && !sda_s_q[1];
  assign stop_c   = scl_s_q[1] && scl_q && !sda_q && sda_s_q[1];

  wire [3:0] opc  = instr_q[quad_pot_pkg::OPC_LSB +: 4];
  wire [1:0] slot = instr_q[quad_pot_pkg::SLOT_LSB +: 2];
  wire [1:0] pot  = instr_q[quad_pot_pkg::POT_LSB +: 2];
  wire [7:0] rx_byte = {sh_q[6:0], sda_q};

  ////////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers and edge history
  always_ff @(posedge i_ref_clk) begin
    pin_s1_q <= i_board_address_pins;
    pin_s2_q <= pin_s1_q;
    if (!i_rst_n) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], link.scl};
      sda_s_q <= {sda_s_q[0], link.sda};
      scl_q   <= scl_s_q[1];
      sda_q   <= sda_s_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frame decoder and register updates
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_q   <= ST_IDLE;
      bit_q     <= 3'h0;
      ack_ph_q  <= 1'b0;
      skip_q    <= 1'b0;
      sh_q      <= 8'h00;
      instr_q   <= 8'h00;
      tx_q      <= 8'h00;
      sda_drv_q <= 1'b0;
      pend_q    <= 1'b0;
      pend_all_q  <= 1'b0;
      pend_slot_q <= 2'h0;
      pend_pot_q  <= 2'h0;
      pend_val_q  <= 6'h00;
      for (int i = 0; i < 4; i++) begin
        wiper_position_register[i] <= quad_pot_pkg::WIPER_RST;
      end
    end else if (start_c) begin
      state_q   <= ST_ADDR;
      bit_q     <= 3'h0;
      ack_ph_q  <= 1'b0;
      sda_drv_q <= 1'b0;
      pend_q    <= 1'b0;  // a restarted frame drops any queued store
      skip_q    <= 1'b1;  // the clock fall that ends the start is no data bit
    end else if (stop_c) begin
      state_q   <= ST_IDLE;
      sda_drv_q <= 1'b0;
      // [R14] queued store is taken by the timer at this stop if the timer is idle, then cleared
      pend_q    <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_WAIT: ;
        ST_ADDR, ST_INSTR, ST_DATA: begin
          if (scl_rise && !ack_ph_q) begin
            sh_q <= rx_byte;
          end
          if (scl_fall && skip_q) begin
            skip_q <= 1'b0;
          end else if (scl_fall && !ack_ph_q) begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == quad_pot_pkg::BIT_LAST) begin
              ack_ph_q <= 1'b1;
              // [R15] address compare
              if (state_q == ST_ADDR && (sh_q[7:4] != quad_pot_pkg::DEV_TYPE ||
                  sh_q[3:0] != pin_s2_q)) begin
                state_q  <= ST_WAIT;
                ack_ph_q <= 1'b0;
              end else begin
                sda_drv_q <= 1'b1;
              end
            end
          end else if (scl_fall && ack_ph_q) begin
            ack_ph_q  <= 1'b0;
            sda_drv_q <= 1'b0;
            unique case (state_q)
              ST_ADDR: state_q <= ST_INSTR;
              ST_INSTR: begin
                instr_q <= sh_q;
                unique case (sh_q[7:4])
                  // [R6] wiper read, [R18] saved read
                  quad_pot_pkg::OP_RD_WIPER: begin
                    tx_q      <= {2'h0, wiper_position_register[sh_q[1:0]]};
                    state_q   <= ST_TXD;
                  end
                  quad_pot_pkg::OP_RD_SAVED: begin
                    tx_q    <= {2'h0, saved_setting_register[sh_q[1:0]][sh_q[3:2]]};
                    state_q <= ST_TXD;
                  end
                  quad_pot_pkg::OP_WR_WIPER, quad_pot_pkg::OP_WR_SAVED: state_q <= ST_DATA;
                  // [R3] stepping begins after ack
                  quad_pot_pkg::OP_STEP: state_q <= ST_STEP;
                  // [R12] single saved-to-wiper
                  quad_pot_pkg::OP_SAVED_TO_WIP: begin
                    wiper_position_register[sh_q[1:0]] <=
                      saved_setting_register[sh_q[1:0]][sh_q[3:2]];
                    state_q <= ST_WAIT;
                  end
                  // [R9] [R1] global saved-to-wiper
                  quad_pot_pkg::OP_G_SAVED_WIP: begin
                    for (int i = 0; i < 4; i++) begin
                      wiper_position_register[i] <= saved_setting_register[i][sh_q[3:2]];
                    end
                    state_q <= ST_WAIT;
                  end
                  // [R11] [R10] queue wiper-to-saved until stop
                  quad_pot_pkg::OP_WIP_TO_SAVED, quad_pot_pkg::OP_G_WIP_SAVED: begin
                    pend_q      <= 1'b1;
                    pend_all_q  <= (sh_q[7:4] == quad_pot_pkg::OP_G_WIP_SAVED);
                    pend_slot_q <= sh_q[3:2];
                    pend_pot_q  <= sh_q[1:0];
                    pend_val_q  <= wiper_position_register[sh_q[1:0]];
                    state_q     <= ST_WAIT;
                  end
                  default: state_q <= ST_WAIT;
                endcase
              end
              ST_DATA: begin
                // [R7] [R20] wiper write drops top bits
                if (opc == quad_pot_pkg::OP_WR_WIPER) begin
                  wiper_position_register[pot] <= sh_q[5:0];
                end else begin
                  // [R8] saved write queued for stop
                  pend_q      <= 1'b1;
                  pend_all_q  <= 1'b0;
                  pend_slot_q <= slot;
                  pend_pot_q  <= pot;
                  pend_val_q  <= sh_q[5:0];
                end
                state_q <= ST_WAIT;
              end
              default: state_q <= ST_WAIT;
            endcase
          end
        end
        ST_TXD: begin
          // device shifts out msb first, then releases for master ack
          if (scl_fall) begin
            bit_q <= bit_q + 3'h1;
            tx_q  <= {tx_q[6:0], 1'b0};
            if (bit_q == quad_pot_pkg::BIT_LAST) begin
              state_q <= ST_WAIT;
            end
          end
        end
        ST_STEP: begin
          // [R13] no ack, [R4] [R5] [R19] saturating step as each pulse ends
          if (scl_fall) begin
            if (sda_q && wiper_position_register[pot] != quad_pot_pkg::WIPER_MAX) begin
              wiper_position_register[pot] <= wiper_position_register[pot] + 6'h01;
            end else if (!sda_q &&
                         wiper_position_register[pot] != quad_pot_pkg::WIPER_MIN) begin
              wiper_position_register[pot] <= wiper_position_register[pot] - 6'h01;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // non-volatile write timer, started only by stop
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      nv_cnt_q <= 32'h0;
      for (int p = 0; p < 4; p++) begin
        for (int s = 0; s < 4; s++) begin
          saved_setting_register[p][s] <= quad_pot_pkg::WIPER_RST;
        end
      end
    end else if (stop_c && pend_q && nv_cnt_q == 32'h0) begin
      // [R14] [R2] store on stop, [R16] then busy
      nv_cnt_q <= 32'(NV_CYC);
      for (int p = 0; p < 4; p++) begin
        if (pend_all_q) begin
          saved_setting_register[p][pend_slot_q] <= wiper_position_register[p];
        end else if (p[1:0] == pend_pot_q) begin
          saved_setting_register[p][pend_slot_q] <= pend_val_q;
        end
      end
    end else if (nv_cnt_q != 32'h0) begin
      nv_cnt_q <= nv_cnt_q - 32'h1;
    end
  end

  // [R17] wiper outputs as 6-bit tap codes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      o_wiper_taps[i*6 +: 6] = wiper_position_register[i];
    end
  end
  assign o_nv_busy = (nv_cnt_q != 32'h0);

  // open-drain drive: ack low or data bit low pulls the line
  assign link.d_sda_o    = 1'b0;
  assign link.d_sda_oe_n = !((sda_drv_q) || (state_q == ST_TXD && !tx_q[7] && !ack_ph_q));
endmodule

// ---- hdl/quad_pot_master.sv ----
// bus master end: issues one command frame per request on the two-wire link
`timescale 1ns/1ps
module quad_pot_master (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // link
  quad_pot_if.master       link,
  // request
  input  wire logic        i_req,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_instr,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_has_data,
  input  wire logic        i_is_read,
  input  wire logic [7:0]  i_step_bits,
  input  wire logic [3:0]  i_step_cnt,
  // answer
  output logic             o_busy,
  output logic             o_done,
  output logic             o_nack,
  output logic [7:0]       o_rd_data
);
  typedef enum logic [5:0] {
    M_IDLE  = 6'b000001,
    M_START = 6'b000010,
    M_BYTE  = 6'b000100,
    M_STEP  = 6'b001000,
    M_STOP  = 6'b010000,
    M_END   = 6'b100000
  } m_state_t;

  m_state_t   st_q;
  logic [7:0] div_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] sh_q;
  logic       scl_q, sda_q, sda_in_q;
  logic [1:0] sda_s_q;
  logic [7:0] addr_q, instr_q, data_q, step_q, rd_q;
  logic [3:0] nstep_q;
  logic       hd_q, rd_is_q, nack_q, done_q;
  logic       tick;
  assign tick = (div_q == 8'(quad_pot_pkg::SCL_HALF_CYC - 1));

  ////////////////////////////////////////////////////////////////////////////////
  // divider and data synchroniser
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      div_q   <= 8'h00;
      sda_s_q <= 2'h3;
    end else begin
      div_q   <= tick ? 8'h00 : div_q + 8'h01;
      sda_s_q <= {sda_s_q[0], link.sda};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frame sequencer: each quarter is one tick; ph 0 set data, 1 rise, 2 sample, 3 fall
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st_q <= M_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      sh_q <= 8'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_in_q <= 1'b1;
      addr_q <= 8'h00;
      instr_q <= 8'h00;
      data_q <= 8'h00;
      step_q <= 8'h00;
      rd_q <= 8'h00;
      nstep_q <= 4'h0;
      hd_q <= 1'b0;
      rd_is_q <= 1'b0;
      nack_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (st_q)
        M_IDLE: if (i_req) begin
          addr_q <= i_addr; instr_q <= i_instr; data_q <= i_data;
          step_q <= i_step_bits; nstep_q <= i_step_cnt;
          hd_q <= i_has_data; rd_is_q <= i_is_read; nack_q <= 1'b0;
          st_q <= M_START; ph_q <= 2'h0;
        end
        M_START: if (tick) begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h0) sda_q <= 1'b0;
          if (ph_q == 2'h1) begin
            scl_q <= 1'b0; st_q <= M_BYTE; bit_q <= 4'h0; byte_q <= 2'h0;
            sh_q <= addr_q; ph_q <= 2'h0;
          end
        end
        M_BYTE: if (tick) begin
          ph_q <= ph_q + 2'h1;
          unique case (ph_q)
            2'h0: sda_q <= (bit_q == 4'h8) ? (rd_is_q && byte_q == 2'h2 ? 1'b1 : 1'b1)
                           : ((rd_is_q && byte_q == 2'h2) ? 1'b1 : sh_q[7]);
            2'h1: scl_q <= 1'b1;
            2'h2: begin
              sda_in_q <= sda_s_q[1];
              if (bit_q == 4'h8 && !(rd_is_q && byte_q == 2'h2) && sda_s_q[1]) nack_q <= 1'b1;
              if (bit_q < 4'h8) rd_q <= {rd_q[6:0], sda_s_q[1]};
            end
            default: begin
              scl_q <= 1'b0;
              sh_q  <= {sh_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h8) begin
                bit_q <= 4'h0;
                byte_q <= byte_q + 2'h1;
                if (byte_q == 2'h0) sh_q <= instr_q;
                else if (byte_q == 2'h1) begin
                  sh_q <= data_q;
                  if (!hd_q && !rd_is_q) st_q <= (nstep_q != 4'h0) ? M_STEP : M_STOP;
                end else st_q <= M_STOP;
                if (nack_q) st_q <= M_STOP;
              end
            end
          endcase
        end
        M_STEP: if (tick) begin
          ph_q <= ph_q + 2'h1;
          unique case (ph_q)
            2'h0: sda_q <= step_q[7];
            2'h1: scl_q <= 1'b1;
            2'h2: sda_in_q <= sda_s_q[1];
            default: begin
              scl_q <= 1'b0; step_q <= {step_q[6:0], 1'b0}; nstep_q <= nstep_q - 4'h1;
              if (nstep_q == 4'h1) st_q <= M_STOP;
            end
          endcase
        end
        M_STOP: if (tick) begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h0) sda_q <= 1'b0;
          if (ph_q == 2'h1) scl_q <= 1'b1;
          if (ph_q == 2'h2) begin sda_q <= 1'b1; st_q <= M_END; end
        end
        default: begin
          st_q   <= M_IDLE;
          done_q <= 1'b1;
        end
      endcase
    end
  end

  // latch read byte at completion
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) o_rd_data <= 8'h00;
    else if (st_q == M_END) o_rd_data <= rd_q;
  end

  assign o_busy = (st_q != M_IDLE);
  assign o_done = done_q;
  assign o_nack = nack_q;
  assign link.scl_o      = 1'b0;
  assign link.scl_oe_n   = scl_q;
  assign link.m_sda_o    = 1'b0;
  assign link.m_sda_oe_n = sda_q;
endmodule

// ---- bench/quad_pot_link_asserts.sv ----
// checker: wire-level framing and timing of the quad pot two-wire link
`timescale 1ns/1ps
module quad_pot_link_asserts (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // link lines and enables
  input  wire logic m_sda_oe_n,
  input  wire logic d_sda_oe_n,
  input  wire logic scl,
  input  wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic [5:0] rise_cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // previous line levels, used to spot a start
  always_ff @(posedge i_ref_clk) begin
    scl_q <= scl;
    sda_q <= sda;
  end

  // clock rises counted since the last start, so ack slots can be located
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rise_cnt_q <= 6'h00;
    end else if (scl && scl_q && sda_q && !sda) begin
      rise_cnt_q <= 6'h00;
    end else if (scl && !scl_q) begin
      rise_cnt_q <= rise_cnt_q + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  // data falls while the clock is high
  sequence start_seq;
    scl && $fell(sda);
  endsequence

  // data rises while the clock is high
  sequence stop_seq;
    scl && $rose(sda);
  endsequence

  a_start_scl_fall: assert property (start_seq |-> ##[1:16] !scl)
    else $error("clock did not fall after a start");
  a_start_by_master: assert property (start_seq |-> d_sda_oe_n)
    else $error("device held data low at a start");
  a_stop_bus_idle: assert property (stop_seq |=> scl [*4])
    else $error("clock fell right after a stop");
  a_scl_high_time: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  a_scl_low_time: assert property ($fell(scl) |-> (!scl) [*8])
    else $error("clock low phase too short");
  a_dev_change_low: assert property ($changed(d_sda_oe_n) |-> !scl)
    else $error("device changed data while clock high");
  a_ack_master_free: assert property (scl && !d_sda_oe_n |-> m_sda_oe_n)
    else $error("master drove data during a device bit");
  a_ack_slot_only: assert property ($rose(scl) && !d_sda_oe_n |->
    rise_cnt_q == 6'h08 || rise_cnt_q == 6'h11 || rise_cnt_q == 6'h1a ||
    (rise_cnt_q >= 6'h12 && rise_cnt_q <= 6'h19))
    else $error("device drove data outside an ack or read slot");
endmodule

// ---- bench/quad_pot_i2c_command_decoder_test.sv ----
// testbench: master and device ends joined, command frames judged at user ports
`timescale 1ns/1ps
module quad_pot_i2c_command_decoder_test;
  localparam int         NV   = 50;
  localparam logic [3:0] PINS = 4'h5;
  localparam logic [7:0] ADR  = {quad_pot_pkg::DEV_TYPE, PINS};
  logic        clk;
  logic        rst_n;
  logic [3:0]  pins;
  logic        req;
  logic [7:0]  addr;
  logic [7:0]  instr;
  logic [7:0]  wdata;
  logic        has_data;
  logic        is_read;
  logic [7:0]  sbits;
  logic [3:0]  scnt;
  logic [23:0] taps;
  logic        nv_busy;
  logic        busy;
  logic        done;
  logic        nack;
  logic [7:0]  rdata;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;

  ////////////////////////////////////////////////////////////////////////////
  // both ends and the wire checker
  quad_pot_if quad_pot_if_i ();
  quad_pot_device #(.NV_CYC(NV)) quad_pot_device_i (
    .i_ref_clk            (clk),
    .i_rst_n              (rst_n),
    .i_board_address_pins (pins),
    .link                 (quad_pot_if_i.device),
    .o_wiper_taps         (taps),
    .o_nv_busy            (nv_busy)
  );
  quad_pot_master quad_pot_master_i (
    .i_ref_clk  (clk),
    .i_rst_n    (rst_n),
    .link       (quad_pot_if_i.master),
    .i_req      (req),
    .i_addr     (addr),
    .i_instr    (instr),
    .i_data     (wdata),
    .i_has_data (has_data),
    .i_is_read  (is_read),
    .i_step_bits(sbits),
    .i_step_cnt (scnt),
    .o_busy     (busy),
    .o_done     (done),
    .o_nack     (nack),
    .o_rd_data  (rdata)
  );
  quad_pot_link_asserts quad_pot_link_asserts_i (
    .i_ref_clk  (clk),
    .i_rst_n    (rst_n),
    .m_sda_oe_n (quad_pot_if_i.m_sda_oe_n),
    .d_sda_oe_n (quad_pot_if_i.d_sda_oe_n),
    .scl        (quad_pot_if_i.scl),
    .sda        (quad_pot_if_i.sda)
  );

  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chk_w(input int p, input logic [5:0] exp);
    check("wiper", 24'(taps[p*6 +: 6]), 24'(exp));
  endtask

  // one frame: request held until busy, then bounded wait for done
  task automatic frame(input logic [7:0] a, input logic [7:0] ins, input logic [7:0] d,
                       input logic hd, input logic rd, input logic [7:0] sb,
                       input logic [3:0] sc);
    int n;
    n = 0;
    addr = a;
    instr = ins;
    wdata = d;
    has_data = hd;
    is_read = rd;
    sbits = sb;
    scnt = sc;
    req = 1'b1;
    while (busy !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    req = 1'b0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("done", 24'(done), 24'h1);
    check("nack", 24'(nack), 24'(a !== ADR));
  endtask

  task automatic cmd(input logic [3:0] op, input logic [1:0] sl, input logic [1:0] po,
                     input logic [7:0] d, input logic hd, input logic rd);
    frame(ADR, {op, sl, po}, d, hd, rd, 8'h00, 4'h0);
  endtask

  // bounded wait for the programming cycle to start after the stop, then to end
  task automatic nv_wait;
    int n;
    n = 0;
    while (nv_busy !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("nv_busy", 24'(nv_busy), 24'h1);
    while (nv_busy !== 1'b0 && n < NV + 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("nv_busy", 24'(nv_busy), 24'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_wiper;
    check("taps", taps, {4{quad_pot_pkg::WIPER_RST}});
    cmd(quad_pot_pkg::OP_WR_WIPER, 2'h0, 2'h2, 8'hff, 1'b1, 1'b0);
    chk_w(2, 6'h3f);
    cmd(quad_pot_pkg::OP_RD_WIPER, 2'h0, 2'h2, 8'h00, 1'b0, 1'b1);
    check("rd", 24'(rdata), 24'h3f);
    $display("test wiper done");
  endtask

  task automatic t_saved;
    cmd(quad_pot_pkg::OP_WR_SAVED, 2'h3, 2'h1, 8'hd5, 1'b1, 1'b0);
    chk_w(1, 6'h20);
    nv_wait();
    cmd(quad_pot_pkg::OP_RD_SAVED, 2'h3, 2'h1, 8'h00, 1'b0, 1'b1);
    check("rd", 24'(rdata), 24'h15);
    cmd(quad_pot_pkg::OP_SAVED_TO_WIP, 2'h3, 2'h1, 8'h00, 1'b0, 1'b0);
    chk_w(1, 6'h15);
    cmd(quad_pot_pkg::OP_WIP_TO_SAVED, 2'h1, 2'h2, 8'h00, 1'b0, 1'b0);
    nv_wait();
    cmd(quad_pot_pkg::OP_RD_SAVED, 2'h1, 2'h2, 8'h00, 1'b0, 1'b1);
    check("rd", 24'(rdata), 24'h3f);
    $display("test saved done");
  endtask

  task automatic t_global;
    cmd(quad_pot_pkg::OP_G_WIP_SAVED, 2'h2, 2'h0, 8'h00, 1'b0, 1'b0);
    nv_wait();
    cmd(quad_pot_pkg::OP_RD_SAVED, 2'h2, 2'h1, 8'h00, 1'b0, 1'b1);
    check("rd", 24'(rdata), 24'h15);
    cmd(quad_pot_pkg::OP_WR_WIPER, 2'h0, 2'h0, 8'h01, 1'b1, 1'b0);
    cmd(quad_pot_pkg::OP_WR_WIPER, 2'h0, 2'h3, 8'h07, 1'b1, 1'b0);
    cmd(quad_pot_pkg::OP_G_SAVED_WIP, 2'h2, 2'h0, 8'h00, 1'b0, 1'b0);
    check("taps", taps, {6'h20, 6'h3f, 6'h15, 6'h20});
    $display("test global done");
  endtask

  task automatic t_step;
    frame(ADR, {quad_pot_pkg::OP_STEP, 4'h2}, 8'h00, 1'b0, 1'b0, 8'h80, 4'h2);
    chk_w(2, 6'h3e);
    cmd(quad_pot_pkg::OP_WR_WIPER, 2'h0, 2'h0, 8'h01, 1'b1, 1'b0);
    frame(ADR, {quad_pot_pkg::OP_STEP, 4'h0}, 8'h00, 1'b0, 1'b0, 8'h10, 4'h4);
    chk_w(0, 6'h01);
    $display("test step done");
  endtask

  task automatic t_bad_addr;
    frame({quad_pot_pkg::DEV_TYPE, ~PINS}, {quad_pot_pkg::OP_WR_WIPER, 4'h1},
          8'h2a, 1'b1, 1'b0, 8'h00, 4'h0);
    check("taps", taps, {6'h20, 6'h3e, 6'h15, 6'h01});
    $display("test bad address done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // 8 ns reference clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      final_report();
    end
  end

  // reset, then the scenarios in order
  initial begin
    rst_n = 1'b0;
    pins = PINS;
    req = 1'b0;
    addr = 8'h00;
    instr = 8'h00;
    wdata = 8'h00;
    has_data = 1'b0;
    is_read = 1'b0;
    sbits = 8'h00;
    scnt = 4'h0;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    t_wiper();
    t_saved();
    t_global();
    t_step();
    t_bad_addr();
    final_report();
  end
endmodule
